// File: design/edam_map.svh
`ifndef EDAM_MAP_SVH
`define EDAM_MAP_SVH

// register byte offsets on the AXI4-Lite slave
`define EDAM_CLK_CTRL_OFS 8'h00
`define EDAM_MEM_MAP_OFS 8'h04
`define EDAM_TIMED_ACC_OFS 8'h08
`define EDAM_PTR_SEL_OFS 8'h0C
`define EDAM_PTR0_OFS 8'h10
`define EDAM_PTR1_OFS 8'h14
`define EDAM_INDEX_OFS 8'h18
`define EDAM_PORT2_OFS 8'h1C
`define EDAM_CMD_OFS 8'h20
`define EDAM_DATA_OFS 8'h24
`define EDAM_STATUS_OFS 8'h28

// field positions
`define EDAM_STRETCH_MSB 2
`define EDAM_STRETCH_LSB 0
`define EDAM_HOLD_EN_BIT 7
`define EDAM_PTR_SEL_BIT 0
`define EDAM_CMD_WRITE_BIT 0
`define EDAM_CMD_PTR_BIT 1
`define EDAM_STAT_BUSY_BIT 0
`define EDAM_STAT_PEND_BIT 1
`define EDAM_STAT_CYC_LSB 16

// reset values
`define EDAM_STRETCH_RST 3'h1
`define EDAM_HOLD_EN_RST 1'h0

// timed access keys and window length in clocks
`define EDAM_TA_KEY1 8'hAA
`define EDAM_TA_KEY2 8'h55
`define EDAM_TA_WINDOW 4'h8

// clock states per machine cycle, base machine cycles of a move
`define EDAM_STATES 4
`define EDAM_BASE_CYCLES 16'h0002
`define EDAM_STROBE_S0 8'h02

`define EDAM_RESP_OKAY 2'h0
`define EDAM_RESP_SLVERR 2'h2

`endif

// File: design/edam_pkg.sv
package edam_pkg;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_fetch = 3'b010,
        st_access = 3'b100
    } edam_mode_t;

    typedef struct packed {
        logic [3:0] phase;
    } edam_phase_state_t;

    typedef struct packed {
        edam_mode_t mode;
        logic [2:0] stretch_select;
        logic hold_input_enable;
        logic ta_armed;
        logic [3:0] ta_cnt;
        logic pointer_select;
        logic [15:0] first_data_pointer;
        logic [15:0] second_data_pointer;
        logic [7:0] working_index;
        logic [7:0] port_two_latch;
        logic cmd_pending;
        logic cmd_write;
        logic cmd_pointer;
        logic [7:0] move_wdata;
        logic [7:0] move_rdata;
        logic [2:0] run_stretch;
        logic [2:0] left;
        logic first_cyc;
        logic held;
        logic rd_strobe;
        logic wr_strobe;
        logic [15:0] ext_addr;
        logic data_oe;
        logic [15:0] cycle_cnt;
        logic [15:0] last_cycles;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } edam_state_t;

endpackage

// File: design/edam_phase.sv
`timescale 1ns/1ps
`include "edam_map.svh"

// free-running machine-cycle state generator, one-hot states one to four
module edam_phase (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    output logic [`EDAM_STATES-1:0] phase
);
    edam_pkg::edam_phase_state_t s_reg;
    edam_pkg::edam_phase_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.phase = {s_reg.phase[`EDAM_STATES-2:0], s_reg.phase[`EDAM_STATES-1]};
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= 4'h1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign phase = s_reg.phase;

    // the release edge itself still loads the reset state, so it starts no check
    one_hot_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !reset) |=> $onehot(phase)
            && phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("machine cycle state not rotating one-hot");
endmodule // edam_phase

// File: design/edam_top.sv
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "edam_map.svh"

// How it works
// - a move starts with a four-clock fetch cycle, address goes out the next cycle
// - stretch_select lives in bits 2-0 of clock_control_register
// - move length is two machine cycles plus the stretch value
// - only the external data move is lengthened, nothing else
// - stretch resets to one, giving three-cycle moves
// - strobe is two clocks at stretch zero, else four clocks per step
// - hold input acts only while hold_input_enable (memory map bit 7) is set
// - stretch still sets the shortest move; holds only lengthen it
// - hold input is sampled in third_state before the strobe ends
// - each seen hold adds one machine cycle with strobe kept active
// - waits are unlimited; move ends the cycle after hold is seen released, or in that cycle at stretch zero
// - hold_input_enable changes only through the timed access sequence
// - a machine cycle is four clocks, states one to four in order
// - indirect moves use port two latch high, index register low
// - pointer_select bit zero picks first or second data pointer
module edam_top #(
    parameter int ADDR_W = 8,
    parameter logic [3:0] TA_WINDOW = `EDAM_TA_WINDOW
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] ext_addr,
    output logic [7:0] ext_wdata,
    output logic ext_data_oe,
    input wire logic [7:0] ext_rdata,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    input wire logic hold_request_n,
    output logic move_busy,
    output logic [3:0] machine_state
);
    edam_pkg::edam_state_t s_reg;
    edam_pkg::edam_state_t s_next;
    logic [3:0] phase;
    logic [3:0] phase_nx;

    edam_phase u_phase (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .phase(phase)
    );

    assign phase_nx = {phase[2:0], phase[3]};

    function automatic logic strobe_on(input logic [3:0] ph, input logic first,
                                       input logic last, input logic held, input logic s0);
        logic pre;
        logic post;
        pre = s0 ? ph[0] : (ph[0] | ph[1]);
        post = s0 ? ph[3] : (ph[2] | ph[3]);
        return !(first && pre) && !(last && !held && post);
    endfunction

    always_comb begin
        logic [7:0] wa;
        logic [31:0] wd;
        logic [3:0] lanes;
        logic whit;
        logic rhit;
        logic [31:0] rv;
        logic [2:0] target;
        logic strobe;
        wa = s_reg.aw_addr;
        wd = s_reg.w_data;
        lanes = s_reg.w_strb;
        whit = 1'b1;
        rhit = 1'b1;
        rv = 32'h0000_0000;
        target = (s_reg.run_stretch == 3'h0) ? 3'h0 : 3'h1;
        strobe = 1'b0;
        s_next = s_reg;

        if (s_reg.ta_cnt != 4'h0) begin
            s_next.ta_cnt = s_reg.ta_cnt - 4'h1;
        end

        // write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.aw_got && s_reg.w_got) begin
            case (wa)
                `EDAM_CLK_CTRL_OFS: begin
                    if (lanes[0]) begin
                        s_next.stretch_select = wd[`EDAM_STRETCH_MSB:`EDAM_STRETCH_LSB];
                    end
                end
                `EDAM_MEM_MAP_OFS: begin
                    // unprotected writes fall through unchanged
                    if (lanes[0] && s_reg.ta_cnt != 4'h0) begin
                        s_next.hold_input_enable = wd[`EDAM_HOLD_EN_BIT];
                        s_next.ta_cnt = 4'h0;
                    end
                end
                `EDAM_TIMED_ACC_OFS: begin
                    if (lanes[0]) begin
                        if (wd[7:0] == `EDAM_TA_KEY1) begin
                            s_next.ta_armed = 1'b1;
                        end else if (s_reg.ta_armed && wd[7:0] == `EDAM_TA_KEY2) begin
                            s_next.ta_armed = 1'b0;
                            s_next.ta_cnt = TA_WINDOW;
                        end else begin
                            s_next.ta_armed = 1'b0;
                        end
                    end
                end
                `EDAM_PTR_SEL_OFS: begin
                    if (lanes[0]) begin
                        s_next.pointer_select = wd[`EDAM_PTR_SEL_BIT];
                    end
                end
                `EDAM_PTR0_OFS: begin
                    if (lanes[0]) begin
                        s_next.first_data_pointer[7:0] = wd[7:0];
                    end
                    if (lanes[1]) begin
                        s_next.first_data_pointer[15:8] = wd[15:8];
                    end
                end
                `EDAM_PTR1_OFS: begin
                    if (lanes[0]) begin
                        s_next.second_data_pointer[7:0] = wd[7:0];
                    end
                    if (lanes[1]) begin
                        s_next.second_data_pointer[15:8] = wd[15:8];
                    end
                end
                `EDAM_INDEX_OFS: begin
                    if (lanes[0]) begin
                        s_next.working_index = wd[7:0];
                    end
                end
                `EDAM_PORT2_OFS: begin
                    if (lanes[0]) begin
                        s_next.port_two_latch = wd[7:0];
                    end
                end
                `EDAM_CMD_OFS: begin
                    // a command while a move is queued or running is dropped
                    if (lanes[0] && s_reg.mode == edam_pkg::st_idle && !s_reg.cmd_pending) begin
                        s_next.cmd_pending = 1'b1;
                        s_next.cmd_write = wd[`EDAM_CMD_WRITE_BIT];
                        s_next.cmd_pointer = wd[`EDAM_CMD_PTR_BIT];
                    end
                end
                `EDAM_DATA_OFS: begin
                    if (lanes[0]) begin
                        s_next.move_wdata = wd[7:0];
                    end
                end
                `EDAM_STATUS_OFS: begin
                end
                default: begin
                    whit = 1'b0;
                end
            endcase
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = whit ? `EDAM_RESP_OKAY : `EDAM_RESP_SLVERR;
        end
        if (s_reg.bvalid && s_axi_bready && clk_en) begin
            s_next.bvalid = 1'b0;
        end

        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            case (s_axi_araddr[7:0])
                `EDAM_CLK_CTRL_OFS: rv[`EDAM_STRETCH_MSB:`EDAM_STRETCH_LSB] = s_reg.stretch_select;
                `EDAM_MEM_MAP_OFS: rv[`EDAM_HOLD_EN_BIT] = s_reg.hold_input_enable;
                `EDAM_TIMED_ACC_OFS: rv = 32'h0000_0000;
                `EDAM_PTR_SEL_OFS: rv[`EDAM_PTR_SEL_BIT] = s_reg.pointer_select;
                `EDAM_PTR0_OFS: rv[15:0] = s_reg.first_data_pointer;
                `EDAM_PTR1_OFS: rv[15:0] = s_reg.second_data_pointer;
                `EDAM_INDEX_OFS: rv[7:0] = s_reg.working_index;
                `EDAM_PORT2_OFS: rv[7:0] = s_reg.port_two_latch;
                `EDAM_CMD_OFS: begin
                    rv[`EDAM_CMD_WRITE_BIT] = s_reg.cmd_write;
                    rv[`EDAM_CMD_PTR_BIT] = s_reg.cmd_pointer;
                end
                `EDAM_DATA_OFS: rv[7:0] = s_reg.move_rdata;
                `EDAM_STATUS_OFS: begin
                    rv[`EDAM_STAT_BUSY_BIT] = (s_reg.mode != edam_pkg::st_idle);
                    rv[`EDAM_STAT_PEND_BIT] = s_reg.cmd_pending;
                    rv[31:`EDAM_STAT_CYC_LSB] = s_reg.last_cycles;
                end
                default: rhit = 1'b0;
            endcase
            s_next.rvalid = 1'b1;
            s_next.rdata = rv;
            s_next.rresp = rhit ? `EDAM_RESP_OKAY : `EDAM_RESP_SLVERR;
        end else if (s_reg.rvalid && s_axi_rready && clk_en) begin
            s_next.rvalid = 1'b0;
        end

        // move sequencer, stepped by the machine-cycle states
        case (s_reg.mode)
            edam_pkg::st_idle: begin
                if (s_reg.cmd_pending && phase[3]) begin
                    s_next.mode = edam_pkg::st_fetch;
                    s_next.cmd_pending = 1'b0;
                    s_next.run_stretch = s_reg.stretch_select;
                    s_next.cycle_cnt = 16'h0001;
                end
            end
            edam_pkg::st_fetch: begin
                // plain fetch cycle, never stretched
                if (phase[3]) begin
                    s_next.mode = edam_pkg::st_access;
                    s_next.left = s_reg.run_stretch;
                    s_next.first_cyc = 1'b1;
                    s_next.held = 1'b0;
                    s_next.cycle_cnt = 16'h0002;
                    s_next.data_oe = s_reg.cmd_write;
                    if (s_reg.cmd_pointer) begin
                        s_next.ext_addr = s_reg.pointer_select ? s_reg.second_data_pointer
                                                               : s_reg.first_data_pointer;
                    end else begin
                        s_next.ext_addr = {s_reg.port_two_latch, s_reg.working_index};
                    end
                end
            end
            edam_pkg::st_access: begin
                if (phase[2] && s_reg.left == target && s_reg.hold_input_enable
                    && !hold_request_n) begin
                    s_next.held = 1'b1;
                end
                if (phase[3]) begin
                    if (s_reg.left == 3'h0 && !s_reg.held) begin
                        s_next.mode = edam_pkg::st_idle;
                        s_next.last_cycles = s_reg.cycle_cnt;
                        s_next.data_oe = 1'b0;
                    end else begin
                        // a held cycle repeats without counting down
                        if (!s_reg.held) begin
                            s_next.left = s_reg.left - 3'h1;
                        end
                        s_next.first_cyc = 1'b0;
                        s_next.held = 1'b0;
                        if (s_reg.cycle_cnt != 16'hFFFF) begin
                            s_next.cycle_cnt = s_reg.cycle_cnt + 16'h0001;
                        end
                    end
                end
            end
            default: begin
                s_next.mode = edam_pkg::st_idle;
            end
        endcase

        if (s_next.mode == edam_pkg::st_access) begin
            strobe = strobe_on(phase_nx, s_next.first_cyc, s_next.left == 3'h0,
                               s_next.held, s_next.run_stretch == 3'h0);
        end
        s_next.rd_strobe = strobe && !s_reg.cmd_write;
        s_next.wr_strobe = strobe && s_reg.cmd_write;
        // read data is taken on the last clock of the strobe
        if (s_reg.rd_strobe && !s_next.rd_strobe) begin
            s_next.move_rdata = ext_rdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.mode <= edam_pkg::st_idle;
            s_reg.stretch_select <= `EDAM_STRETCH_RST;
            s_reg.hold_input_enable <= `EDAM_HOLD_EN_RST;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // a frozen clock enable also withholds handshakes so nothing is lost
    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid && clk_en;
    assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid && clk_en;
    assign s_axi_bvalid = s_reg.bvalid && clk_en;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid && clk_en;
    assign s_axi_rvalid = s_reg.rvalid && clk_en;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign ext_addr = s_reg.ext_addr;
    assign ext_wdata = s_reg.move_wdata;
    assign ext_data_oe = s_reg.data_oe;
    assign rd_strobe_n = !s_reg.rd_strobe;
    assign wr_strobe_n = !s_reg.wr_strobe;
    assign move_busy = (s_reg.mode != edam_pkg::st_idle);
    assign machine_state = phase;

    // helper state for the checks below
    logic [7:0] width_cnt;
    logic waited;
    logic stretch_written;
    logic strobe_any;
    assign strobe_any = s_reg.rd_strobe | s_reg.wr_strobe;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            width_cnt <= 8'h00;
            waited <= 1'b0;
            stretch_written <= 1'b0;
        end else if (clk_en) begin
            width_cnt <= strobe_any ? ((width_cnt == 8'hFF) ? width_cnt : width_cnt + 8'h01)
                                    : 8'h00;
            if (s_reg.mode == edam_pkg::st_fetch) begin
                waited <= 1'b0;
            end else if (s_next.held) begin
                waited <= 1'b1;
            end
            if (s_reg.aw_got && s_reg.w_got && s_reg.aw_addr == `EDAM_CLK_CTRL_OFS) begin
                stretch_written <= 1'b1;
            end
        end
    end

    strobe_width_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && strobe_any && !(s_next.rd_strobe | s_next.wr_strobe) && !waited
         && !s_next.held)
        |-> (width_cnt + 8'h01) == ((s_reg.run_stretch == 3'h0) ? `EDAM_STROBE_S0
                                    : {3'h0, s_reg.run_stretch, 2'h0}))
        else $error("strobe width does not match stretch");

    move_length_a: assert property (@(posedge clk) disable iff (reset)
        ($fell(move_busy) && !waited) |-> s_reg.last_cycles ==
            (`EDAM_BASE_CYCLES + {13'h0000, s_reg.run_stretch}))
        else $error("move length is not two plus stretch");

    min_length_a: assert property (@(posedge clk) disable iff (reset)
        $fell(move_busy) |-> s_reg.last_cycles >=
            (`EDAM_BASE_CYCLES + {13'h0000, s_reg.run_stretch}))
        else $error("move shorter than stretch allows");

    reset_stretch_a: assert property (@(posedge clk) disable iff (reset)
        !stretch_written |-> s_reg.stretch_select == `EDAM_STRETCH_RST)
        else $error("stretch value lost its reset setting");

    hold_gate_a: assert property (@(posedge clk) disable iff (reset)
        !s_reg.hold_input_enable |-> !s_next.held)
        else $error("hold honoured while disabled");

    hold_sample_a: assert property (@(posedge clk) disable iff (reset)
        $rose(s_reg.held) |-> $past(phase[2]) && $past(!hold_request_n))
        else $error("hold taken outside third state");

    ta_protect_a: assert property (@(posedge clk) disable iff (reset)
        $changed(s_reg.hold_input_enable) |-> $past(s_reg.ta_cnt) != 4'h0)
        else $error("hold enable changed without timed access");

    fetch_first_a: assert property (@(posedge clk) disable iff (reset)
        (s_reg.mode == edam_pkg::st_access && $past(s_reg.mode) == edam_pkg::st_fetch)
        |-> $past(phase[3]) && phase[0])
        else $error("access cycle not preceded by a full fetch");

    stretch_latch_a: assert property (@(posedge clk) disable iff (reset)
        (s_reg.mode != edam_pkg::st_idle && $past(s_reg.mode) != edam_pkg::st_idle)
        |-> $stable(s_reg.run_stretch))
        else $error("stretch changed during a move");

    held_strobe_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && s_reg.held && phase[3]) |=> strobe_any)
        else $error("strobe dropped in an inserted wait cycle");
endmodule // edam_top

// File: sim/edam_ext_mem.sv
`timescale 1ns/1ps
// external data memory with a slow-peripheral hold, 256 bytes on the low address byte
module edam_ext_mem (
    input wire logic clk,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic ext_data_oe,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [3:0] machine_state,
    input wire logic [3:0] waits,
    output logic [7:0] ext_rdata,
    output logic hold_request_n
);
    logic [7:0] mem [256];
    logic [3:0] seen = 4'h0;
    logic [7:0] last = 8'h00;
    wire act = !rd_strobe_n || !wr_strobe_n;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    // released bus shows the inverse of the last byte, so a late sample cannot match
    assign ext_rdata = rd_strobe_n ? ~last : mem[ext_addr[7:0]];
    // hold low before each third state until the commanded waits are used up
    assign hold_request_n = !(act && seen < waits);
    always @(posedge clk) begin
        if (!act) seen <= 4'h0;
        else if (machine_state[2]) seen <= seen + 4'h1;
        if (!rd_strobe_n) last <= mem[ext_addr[7:0]];
        if (!wr_strobe_n && ext_data_oe) mem[ext_addr[7:0]] <= ext_wdata;
    end
endmodule // edam_ext_mem

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, oe, rd_n, wr_n, hold_n, busy;
    logic [1:0] bresp, rresp, rr, br;
    logic [15:0] ext_addr, sw = 16'h0;
    logic [7:0] ext_wdata, ext_rdata;
    logic [3:0] mstate, sv, waits = 4'h0;
    int fails = 0, num_checks = 0;
    // stretch, machine cycles, strobe clocks
    logic [7:0] rows [8][3] = '{'{8'h0, 8'h2, 8'h2}, '{8'h1, 8'h3, 8'h4}, '{8'h2, 8'h4, 8'h8},
        '{8'h3, 8'h5, 8'hC}, '{8'h4, 8'h6, 8'h10}, '{8'h5, 8'h7, 8'h14}, '{8'h6, 8'h8, 8'h18},
        '{8'h7, 8'h9, 8'h1C}};
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (!rd_n || !wr_n) sw <= sw + 16'h1;
    edam_top u_dut (.clk(clk), .reset(reset), .clk_en(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_data_oe(oe), .ext_rdata(ext_rdata),
        .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .hold_request_n(hold_n), .move_busy(busy),
        .machine_state(mstate));
    edam_ext_mem u_mem (.clk(clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_data_oe(oe), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .machine_state(mstate),
        .waits(waits), .ext_rdata(ext_rdata), .hold_request_n(hold_n));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        r = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // one move; r holds the status word afterwards
    task automatic move(input logic [2:0] s, input logic [31:0] cmd, input logic [3:0] n);
        wr(8'h00, {29'h0, s});
        waits <= n;
        sw <= 16'h0;
        wr(8'h20, cmd);
        @(posedge clk iff busy);
        @(posedge clk iff !busy);
        rd(8'h28);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00);
        chk("stretch_rst", 32'h1, r);
        rd(8'h04);
        chk("hold_en_rst", 32'h0, r);
        wr(8'h18, 32'h33);
        wr(8'h1C, 32'h12);
        chk("bresp_ok", 32'h0, {30'h0, br});
        for (int i = 0; i < 8; i++) begin
            move(rows[i][0][2:0], 32'h0, 4'h0);
            chk("cycles", {8'h0, rows[i][1]}, {16'h0, r[31:16]});
            chk("strobe", {8'h0, rows[i][2]}, {16'h0, sw});
        end
        chk("ind_addr", 32'h1233, {16'h0, ext_addr});
        rd(8'h24);
        chk("rd_data", 32'h69, r);
        move(3'h1, 32'h0, 4'h3);
        chk("hold_off", 32'h3, {16'h0, r[31:16]});
        wr(8'h04, 32'h80);
        rd(8'h04);
        chk("unprot", 32'h0, r);
        wr(8'h08, 32'hAA);
        wr(8'h08, 32'h55);
        wr(8'h04, 32'h80);
        rd(8'h04);
        chk("prot", 32'h80, r);
        move(3'h1, 32'h0, 4'h3);
        chk("hold_cyc", 32'h6, {16'h0, r[31:16]});
        chk("hold_strb", 32'h10, {16'h0, sw});
        move(3'h0, 32'h0, 4'h2);
        chk("hold_s0", 32'h4, {16'h0, r[31:16]});
        move(3'h2, 32'h0, 4'h0);
        chk("hold_min", 32'h4, {16'h0, r[31:16]});
        wr(8'h0C, 32'hFF);
        rd(8'h0C);
        chk("ptr_sel", 32'h1, r);
        wr(8'h14, 32'h00A7);
        wr(8'h24, 32'hC3);
        move(3'h0, 32'h3, 4'h0);
        chk("ptr_addr", 32'hA7, {16'h0, ext_addr});
        move(3'h0, 32'h2, 4'h0);
        rd(8'h24);
        chk("ptr_data", 32'hC3, r);
        rd(8'h40);
        chk("unmapped", 32'h2, {30'h0, rr});
        wr(8'h40, 32'h0);
        chk("unmapped_w", 32'h2, {30'h0, br});
        // three frozen clocks would move a running ring to another state
        ce <= 1'b0;
        @(posedge clk);
        sv = mstate;
        repeat (3) @(posedge clk);
        chk("freeze", {28'h0, sv}, {28'h0, mstate});
        ce <= 1'b1;
        // reset in mid-run brings back the reset settings
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        chk("state_rst", 32'h1, {28'h0, mstate});
        reset <= 1'b0;
        rd(8'h00);
        chk("stretch_rst2", 32'h1, r);
        rd(8'h04);
        chk("hold_en_rst2", 32'h0, r);
        complete_run();
    end
endmodule // testbench
